// ===== verilog/tcx_consts.vh
`ifndef TCX_CONSTS_VH
`define TCX_CONSTS_VH
// Register indices; byte address is four times the index
`define TCX_IDX_SENSE 32'h00fffd6a
`define TCX_IDX_VBASE 32'h00fffd80
`define TCX_IDX_MSTOP 32'h00fffdc8
`define TCX_IDX_STATUS 32'h00fffd70
`define TCX_IDX_ACT_A 32'h00ffff20
`define TCX_IDX_CTRL 32'h00ffff30
`define TCX_IDX_IRQEN 32'h00ffff34
// Field positions
`define TCX_BIT_LINE0_ACT 15
`define TCX_BIT_STOP_FLAG 0
`define TCX_BIT_LINE0_EN 0
`define TCX_BIT_MSTOP 12
`define TCX_BIT_PENDING 0
`define TCX_BIT_AREA_SIDE 4
// Field encodings
`define TCX_MODE_NORMAL 2'h0
`define TCX_MODE_REPEAT 2'h1
`define TCX_MODE_BLOCK 2'h2
`define TCX_SIZE_BYTE 2'h0
`define TCX_SIZE_WORD 2'h1
`define TCX_SIZE_LONG 2'h2
`define TCX_STEP_INC 2'h2
`define TCX_STEP_DEC 2'h3
`define TCX_SENSE_LOW 2'h0
`define TCX_SENSE_FALL 2'h1
`define TCX_SENSE_RISE 2'h2
// Reset values
`define TCX_RST_SENSE 16'h0000
`define TCX_RST_VBASE 32'h00000000
`define TCX_RST_ACT_A 16'h0000
`define TCX_RST_IRQEN 16'h0000
`define TCX_RST_MSTOP 16'h1000
// Vector entry offset of external line 0, from the vector base
`define TCX_VEC_OFS_LINE0 32'h00000040
// Transfer information layout: three words from the info start
`define TCX_INFO_W0 32'h00000000
`define TCX_INFO_W1 32'h00000004
`define TCX_INFO_W2 32'h00000008
`endif

// ===== verilog/tcx_transfer_ctrl.v
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "tcx_consts.vh"

module tcx_transfer_ctrl (
   clk,
   rstn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   ext_irq_line0_n,
   nmi_req,
   mem_req,
   mem_we,
   mem_size,
   mem_addr,
   mem_wdata,
   mem_rdata,
   mem_ack,
   mem_err,
   cpu_ext_irq_line0,
   xfer_busy
);
   input wire clk;
   input wire rstn;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [31:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output wire pready;
   output wire pslverr;
   input wire ext_irq_line0_n; // External line 0 pin, active low
   input wire nmi_req; // Non-maskable request, taken on its rising edge
   output reg mem_req; // Memory request, held until mem_ack
   output reg mem_we;
   output reg [1:0] mem_size; // 0 byte, 1 word, 2 long
   output reg [31:0] mem_addr;
   output reg [31:0] mem_wdata;
   input wire [31:0] mem_rdata;
   input wire mem_ack;
   input wire mem_err; // Address error, valid with mem_ack
   output wire cpu_ext_irq_line0; // Line 0 request passed to the CPU
   output wire xfer_busy;

   // Controller states
   localparam ST_IDLE = 4'h0;
   localparam ST_VEC = 4'h1;
   localparam ST_INFO0 = 4'h2;
   localparam ST_INFO1 = 4'h3;
   localparam ST_INFO2 = 4'h4;
   localparam ST_READ = 4'h5;
   localparam ST_WRITE = 4'h6;
   localparam ST_WB0 = 4'h7;
   localparam ST_WB1 = 4'h8;
   localparam ST_WB2 = 4'h9;

   // Software-visible registers
   reg [15:0] sense_ff;
   reg [31:0] vbase_ff;
   reg [15:0] act_a_ff;
   reg stop_flag_ff;
   reg [15:0] irqen_ff;
   reg [15:0] mstop_ff;
   reg pending_ff; // Line 0 request latched by the interrupt logic
   // Pin synchronisers and edge history
   reg line_s1_ff, line_s2_ff, line_prev_ff;
   reg nmi_s1_ff, nmi_s2_ff, nmi_prev_ff;
   // Engine state and working copy of transfer information
   reg [3:0] state_ff;
   reg [31:0] info_ff; // Info start address from the vector entry
   reg [7:0] mode_a_ff;
   reg [7:0] mode_b_ff;
   reg [31:0] src_ff;
   reg [31:0] dst_ff;
   reg [15:0] cra_ff;
   reg [15:0] crb_ff;
   reg [31:0] area_start_ff; // Start of the block area side, put back after each block
   reg finish_ff; // Activation ends with the count exhausted

   // Decoded fields of the working mode words
   wire [1:0] op_mode = mode_a_ff[7:6];
   wire [1:0] xsize = mode_a_ff[5:4];
   wire [1:0] src_step = mode_a_ff[3:2];
   wire area_side_select = mode_b_ff[`TCX_BIT_AREA_SIDE];
   wire [1:0] dst_step = mode_b_ff[3:2];
   wire block_mode = (op_mode == `TCX_MODE_BLOCK);

   // Pointer update for a step field and element size
   function [31:0] tcx_step;
      input [31:0] ptr;
      input [1:0] step;
      input [1:0] size;
      reg [31:0] amt;
      begin
         amt = (size == `TCX_SIZE_BYTE) ? 32'h1 :
               (size == `TCX_SIZE_WORD) ? 32'h2 : 32'h4;
         if (step == `TCX_STEP_INC) begin
            tcx_step = ptr + amt;
         end else if (step == `TCX_STEP_DEC) begin
            tcx_step = ptr - amt;
         end else begin
            tcx_step = ptr;
         end
      end
   endfunction

   // Register index match; byte address is four times the index
   function tcx_hit;
      input [31:0] addr;
      input [31:0] idx;
      begin
         tcx_hit = (addr == {idx[29:0], 2'b00});
      end
   endfunction

   // APB decode; registers answer with no wait states
   wire hit_sense = tcx_hit(paddr, `TCX_IDX_SENSE);
   wire hit_vbase = tcx_hit(paddr, `TCX_IDX_VBASE);
   wire hit_mstop = tcx_hit(paddr, `TCX_IDX_MSTOP);
   wire hit_status = tcx_hit(paddr, `TCX_IDX_STATUS);
   wire hit_act = tcx_hit(paddr, `TCX_IDX_ACT_A);
   wire hit_ctrl = tcx_hit(paddr, `TCX_IDX_CTRL);
   wire hit_irqen = tcx_hit(paddr, `TCX_IDX_IRQEN);
   wire hit_any = hit_sense | hit_vbase | hit_mstop | hit_status | hit_act | hit_ctrl | hit_irqen;
   wire apb_wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // Read mux; unmapped addresses read zero with pslverr
   always @* begin
      prdata = 32'h0;
      if (hit_sense) begin
         prdata = {16'h0, sense_ff};
      end else if (hit_vbase) begin
         prdata = vbase_ff;
      end else if (hit_mstop) begin
         prdata = {16'h0, mstop_ff};
      end else if (hit_status) begin
         prdata = {31'h0, pending_ff};
      end else if (hit_act) begin
         prdata = {16'h0, act_a_ff};
      end else if (hit_ctrl) begin
         prdata = {31'h0, stop_flag_ff};
      end else if (hit_irqen) begin
         prdata = {16'h0, irqen_ff};
      end
   end

   // Request detection on the synchronised pin
   wire line_fall = line_prev_ff & ~line_s2_ff;
   wire line_rise = ~line_prev_ff & line_s2_ff;
   reg line_event;
   always @* begin
      case (sense_ff[1:0])
         `TCX_SENSE_LOW: line_event = ~line_s2_ff;
         `TCX_SENSE_FALL: line_event = line_fall;
         `TCX_SENSE_RISE: line_event = line_rise;
         default: line_event = line_fall | line_rise;
      endcase
   end
   wire line0_enable = irqen_ff[`TCX_BIT_LINE0_EN];
   wire line0_activation_bit = act_a_ff[`TCX_BIT_LINE0_ACT];
   wire xfer_ctrl_module_stop = mstop_ff[`TCX_BIT_MSTOP];
   wire nmi_event = nmi_s2_ff & ~nmi_prev_ff;
   // A request starts the engine only if routed, running and not stopped
   wire start = (state_ff == ST_IDLE) & pending_ff & line0_activation_bit
                & ~xfer_ctrl_module_stop & ~stop_flag_ff;
   // While routed to the engine the CPU does not see the request
   assign cpu_ext_irq_line0 = pending_ff & line0_enable & ~line0_activation_bit;
   assign xfer_busy = (state_ff != ST_IDLE);

   // Synchronisers: the first stage feeds only the second
   always @(posedge clk) begin
      if (!rstn) begin
         line_s1_ff <= 1'b1;
         line_s2_ff <= 1'b1;
         line_prev_ff <= 1'b1;
         nmi_s1_ff <= 1'b0;
         nmi_s2_ff <= 1'b0;
         nmi_prev_ff <= 1'b0;
      end else begin
         line_s1_ff <= ext_irq_line0_n;
         line_s2_ff <= line_s1_ff;
         line_prev_ff <= line_s2_ff;
         nmi_s1_ff <= nmi_req;
         nmi_s2_ff <= nmi_s1_ff;
         nmi_prev_ff <= nmi_s2_ff;
      end
   end

   // Block area side keeps its start address across a block
   wire mem_done = mem_req & mem_ack;
   wire act_done = (state_ff == ST_WB2) & mem_done & ~mem_err & finish_ff; // Finished activation ends here
   wire block_end = block_mode & (cra_ff[7:0] == 8'h01);
   wire [31:0] nxt_src_step = tcx_step(src_ff, src_step, xsize);
   wire [31:0] nxt_dst_step = tcx_step(dst_ff, dst_step, xsize);
   // Block size of 0 means 256 elements
   wire [15:0] reload_cra = {cra_ff[15:8], cra_ff[15:8]};

   // Software registers and hardware-set flags
   always @(posedge clk) begin
      if (!rstn) begin
         sense_ff <= `TCX_RST_SENSE;
         vbase_ff <= `TCX_RST_VBASE;
         act_a_ff <= `TCX_RST_ACT_A;
         irqen_ff <= `TCX_RST_IRQEN;
         mstop_ff <= `TCX_RST_MSTOP;
         stop_flag_ff <= 1'b0;
         pending_ff <= 1'b0;
      end else begin
         if (apb_wr & hit_sense) begin
            sense_ff <= pwdata[15:0];
         end
         if (apb_wr & hit_vbase) begin
            vbase_ff <= pwdata;
         end
         if (apb_wr & hit_irqen) begin
            irqen_ff <= pwdata[15:0];
         end
         if (apb_wr & hit_mstop) begin
            mstop_ff <= pwdata[15:0];
         end
         // Hardware clear of the activation bit beats a software write
         if (act_done) begin
            act_a_ff <= act_a_ff & ~(16'h1 << `TCX_BIT_LINE0_ACT);
         end else if (apb_wr & hit_act) begin
            act_a_ff <= pwdata[15:0];
         end
         // Stop flag: set wins, software may only write 0
         if (nmi_event || (mem_done && mem_err)) begin
            stop_flag_ff <= 1'b1;
         end else if (apb_wr && hit_ctrl && !pwdata[`TCX_BIT_STOP_FLAG]) begin
            stop_flag_ff <= 1'b0;
         end
         // Pending request: new event wins over engine take or CPU clear
         if ((line_event && line0_enable) || act_done) begin // Last request goes on to the CPU
            pending_ff <= 1'b1;
         end else if (start) begin
            pending_ff <= 1'b0;
         end else if (apb_wr && hit_status && !pwdata[`TCX_BIT_PENDING]) begin
            pending_ff <= 1'b0;
         end
      end
   end

   // Engine: fetch info, move elements, write info back
   always @(posedge clk) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_size <= `TCX_SIZE_LONG;
         mem_addr <= 32'h0;
         mem_wdata <= 32'h0;
         info_ff <= 32'h0;
         mode_a_ff <= 8'h0;
         mode_b_ff <= 8'h0;
         src_ff <= 32'h0;
         dst_ff <= 32'h0;
         cra_ff <= 16'h0;
         crb_ff <= 16'h0;
         area_start_ff <= 32'h0;
         finish_ff <= 1'b0;
      end else if (mem_done && mem_err) begin
         // Any address error ends the activation; no further writeback follows
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  // Vector entry holds the info start address
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_size <= `TCX_SIZE_LONG;
                  mem_addr <= vbase_ff + `TCX_VEC_OFS_LINE0;
                  state_ff <= ST_VEC;
               end
            end
            ST_VEC: begin
               if (mem_done) begin
                  info_ff <= mem_rdata;
                  mem_addr <= mem_rdata + `TCX_INFO_W0;
                  state_ff <= ST_INFO0;
               end
            end
            ST_INFO0: begin
               if (mem_done) begin
                  mode_a_ff <= mem_rdata[31:24];
                  src_ff <= {8'h0, mem_rdata[23:0]};
                  mem_addr <= info_ff + `TCX_INFO_W1;
                  state_ff <= ST_INFO1;
               end
            end
            ST_INFO1: begin
               if (mem_done) begin
                  mode_b_ff <= mem_rdata[31:24];
                  dst_ff <= {8'h0, mem_rdata[23:0]};
                  mem_addr <= info_ff + `TCX_INFO_W2;
                  state_ff <= ST_INFO2;
               end
            end
            ST_INFO2: begin
               if (mem_done) begin
                  cra_ff <= mem_rdata[31:16];
                  crb_ff <= mem_rdata[15:0];
                  area_start_ff <= area_side_select ? src_ff : dst_ff;
                  finish_ff <= 1'b0;
                  mem_size <= mode_a_ff[5:4];
                  mem_addr <= src_ff;
                  state_ff <= ST_READ;
               end
            end
            ST_READ: begin
               if (mem_done) begin
                  mem_we <= 1'b1;
                  mem_wdata <= mem_rdata;
                  mem_addr <= dst_ff;
                  state_ff <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (mem_done) begin
                  if (block_mode) begin
                     // Both pointers step within a block; the block area one goes back at its end
                     if (block_end) begin
                        src_ff <= area_side_select ? area_start_ff : nxt_src_step;
                        dst_ff <= area_side_select ? nxt_dst_step : area_start_ff;
                        cra_ff <= reload_cra;
                        crb_ff <= crb_ff - 16'h1;
                        finish_ff <= (crb_ff == 16'h1);
                        mem_size <= `TCX_SIZE_LONG;
                        mem_addr <= info_ff + `TCX_INFO_W0;
                        mem_wdata <= {mode_a_ff, area_side_select ? area_start_ff[23:0] : nxt_src_step[23:0]};
                        state_ff <= ST_WB0;
                     end else begin
                        src_ff <= nxt_src_step;
                        dst_ff <= nxt_dst_step;
                        cra_ff <= {cra_ff[15:8], cra_ff[7:0] - 8'h1};
                        mem_we <= 1'b0;
                        mem_addr <= nxt_src_step;
                        state_ff <= ST_READ;
                     end
                  end else begin
                     // Normal or repeat: one element per activation
                     src_ff <= nxt_src_step;
                     dst_ff <= nxt_dst_step;
                     if (op_mode == `TCX_MODE_REPEAT) begin
                        cra_ff <= (cra_ff[7:0] == 8'h01) ? reload_cra : {cra_ff[15:8], cra_ff[7:0] - 8'h1};
                        finish_ff <= 1'b0;
                     end else begin
                        cra_ff <= cra_ff - 16'h1;
                        finish_ff <= (cra_ff == 16'h1);
                     end
                     mem_size <= `TCX_SIZE_LONG;
                     mem_addr <= info_ff + `TCX_INFO_W0;
                     mem_wdata <= {mode_a_ff, nxt_src_step[23:0]};
                     state_ff <= ST_WB0;
                  end
               end
            end
            ST_WB0: begin
               if (mem_done) begin
                  mem_addr <= info_ff + `TCX_INFO_W1;
                  mem_wdata <= {mode_b_ff, dst_ff[23:0]};
                  state_ff <= ST_WB1;
               end
            end
            ST_WB1: begin
               if (mem_done) begin
                  mem_addr <= info_ff + `TCX_INFO_W2;
                  mem_wdata <= {cra_ff, crb_ff};
                  state_ff <= ST_WB2;
               end
            end
            ST_WB2: begin
               if (mem_done) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               mem_req <= 1'b0;
               mem_we <= 1'b0;
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // tcx_transfer_ctrl

// ===== sim/tcx_transfer_ctrl_assertions.sv
`timescale 1ns/10ps
// Port-level checks of the transfer controller, single clock domain
module tcx_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [1:0] mem_size,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_err,
   input wire logic cpu_ext_irq_line0,
   input wire logic xfer_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Zero wait states on the register bus
   ready_high_a: assert property (pready) else $error("pready low");
   // Error response only in an access phase, with zero data
   err_phase_a: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
   err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("data with pslverr");
   // A memory request holds all its qualifiers until acknowledged
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_size) && $stable(mem_wdata)) else $error("memory request changed early");
   busy_req_a: assert property (mem_req |-> xfer_busy) else $error("request while idle");
   // Every activation opens with a 32-bit vector read
   first_vec_a: assert property ($rose(mem_req) |-> !mem_we && mem_size == 2'h2)
      else $error("activation not opened by vector read");
   // An address error ends the activation at once
   abort_err_a: assert property (mem_req && mem_ack && mem_err |=> !mem_req) else $error("no abort");
   // A byte read is followed by the write of the same byte
   byte_copy_a: assert property (mem_req && mem_ack && !mem_err && !mem_we && mem_size == 2'h0
      |=> mem_req && mem_we && mem_size == 2'h0 && mem_wdata[7:0] == $past(mem_rdata[7:0]))
      else $error("byte copy broken");
   // CPU request stays quiet while the engine owns the line
   irq_quiet_a: assert property (mem_req |-> !cpu_ext_irq_line0) else $error("cpu request during transfer");
endmodule // tcx_chk

bind tcx_transfer_ctrl tcx_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
   .mem_err(mem_err), .cpu_ext_irq_line0(cpu_ext_irq_line0), .xfer_busy(xfer_busy));

// ===== sim/tcx_mem_model.sv
`timescale 1ns/10ps
// Byte-addressed memory behind the engine; one-cycle acknowledge
module tcx_mem_model (
   input wire logic clk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [1:0] mem_size,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic mem_err
);
   logic [7:0] m [int unsigned]; // Sparse byte store
   int wait_n = 0; // Wait states before each answer
   logic [31:0] err_addr = 32'hffffffff; // Address answered with an error
   int cnt = 0; // Wait states spent
   initial begin
      mem_rdata = 32'h0;
      mem_ack = 1'b0;
      mem_err = 1'b0;
   end
   // Unwritten bytes read as zero
   function automatic logic [7:0] rb(input logic [31:0] a);
      rb = m.exists(a) ? m[a] : 8'h00;
   endfunction
   function automatic logic [31:0] get32(input logic [31:0] a);
      get32 = {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)};
   endfunction
   task automatic put32(input logic [31:0] a, input logic [31:0] v);
      for (int i = 0; i < 4; i++) m[a + i] = v[8*i +: 8];
   endtask
   // Outside an answer the data turns over, so stale data never looks valid
   always @(posedge clk) begin
      if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && mem_we && !mem_err)
            for (int i = 0; i < (1 << mem_size); i++) m[mem_addr + i] = mem_wdata[8*i +: 8];
      end else if (mem_req && cnt < wait_n) begin
         cnt <= cnt + 1;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req) begin
         cnt <= 0;
         mem_ack <= 1'b1;
         mem_err <= (mem_addr == err_addr);
         mem_rdata <= mem_we ? ~mem_rdata : get32(mem_addr);
      end else
         mem_rdata <= ~mem_rdata;
   end
endmodule // tcx_mem_model

// ===== sim/tcx_transfer_ctrl_tb.sv
`timescale 1ns/10ps
`include "tcx_consts.vh"
// Bench: APB register access, line 0 events, memory behind the engine
module tcx_transfer_ctrl_tb;
   logic clk, rstn, psel, penable, pwrite, ext_irq_line0_n, nmi_req;
   logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
   logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, cpu_ext_irq_line0, xfer_busy;
   logic [1:0] mem_size;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   localparam logic [31:0] SRC = 32'h00001000, DST = 32'h00ff9000, INFO = 32'h00ffb000, VB = 32'h00002000;
   tcx_transfer_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_line0_n(ext_irq_line0_n),
      .nmi_req(nmi_req), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
      .cpu_ext_irq_line0(cpu_ext_irq_line0), .xfer_busy(xfer_busy));
   tcx_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer; ends one idle cycle later so strobes never bounce
   task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= idx << 2;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [31:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rc(input logic [31:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 32'h0, r, e);
      chk(r, exp);
   endtask
   // Engine must stay off the memory for a while
   task automatic no_start;
      logic seen;
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk);
         if (mem_req !== 1'b0) seen = 1'b1;
      end
      chk(seen, 1'b0);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rc(`TCX_IDX_SENSE, `TCX_RST_SENSE);
      rc(`TCX_IDX_VBASE, `TCX_RST_VBASE);
      rc(`TCX_IDX_MSTOP, `TCX_RST_MSTOP);
      rc(`TCX_IDX_ACT_A, `TCX_RST_ACT_A);
      rc(`TCX_IDX_IRQEN, `TCX_RST_IRQEN);
      apb(1'b0, 32'h00fffd00, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      wr(`TCX_IDX_VBASE, VB);
      rc(`TCX_IDX_VBASE, VB);
      wr(`TCX_IDX_SENSE, `TCX_SENSE_FALL);
      wr(`TCX_IDX_IRQEN, 32'h1);
      wr(`TCX_IDX_ACT_A, 32'h8000);
      rc(`TCX_IDX_ACT_A, 32'h8000);
      $display("registers done");
   endtask
   // Pending request held back by module stop and stop flag
   task automatic t_gate;
      ext_irq_line0_n <= 1'b0;
      no_start;
      rc(`TCX_IDX_STATUS, 32'h1);
      nmi_req <= 1'b1;
      tick(3);
      nmi_req <= 1'b0;
      tick(6);
      rc(`TCX_IDX_CTRL, 32'h1);
      wr(`TCX_IDX_MSTOP, 32'h0);
      no_start;
      wr(`TCX_IDX_CTRL, 32'h1);
      rc(`TCX_IDX_CTRL, 32'h1);
      wr(`TCX_IDX_CTRL, 32'h0);
      tick(1);
      chk(xfer_busy, 1'b1);
      for (int n = 0; n < 3000 && cpu_ext_irq_line0 !== 1'b1; n++) @(posedge clk);
      chk(cpu_ext_irq_line0, 1'b1);
      chk(xfer_busy, 1'b0);
      $display("gating done");
   endtask
   // One block of 128 bytes, block area on the destination side
   task automatic t_result;
      for (int i = 0; i < 128; i++) chk(mem.rb(DST + i), i);
      chk(mem.rb(DST + 128), 32'h5a);
      chk(mem.get32(INFO), {8'h88, 24'(SRC + 128)});
      chk(mem.get32(INFO + 4), {8'h08, DST[23:0]});
      chk(mem.get32(INFO + 8), 32'h80800000);
      rc(`TCX_IDX_ACT_A, 32'h0);
      $display("block done");
   endtask
   task automatic t_sense;
      wr(`TCX_IDX_STATUS, 32'h0);
      chk(cpu_ext_irq_line0, 1'b0);
      ext_irq_line0_n <= 1'b1;
      tick(6);
      rc(`TCX_IDX_STATUS, 32'h0);
      wr(`TCX_IDX_IRQEN, 32'h0);
      ext_irq_line0_n <= 1'b0;
      tick(6);
      rc(`TCX_IDX_STATUS, 32'h0);
      wr(`TCX_IDX_IRQEN, 32'h1);
      ext_irq_line0_n <= 1'b1;
      tick(6);
      ext_irq_line0_n <= 1'b0;
      no_start;
      rc(`TCX_IDX_STATUS, 32'h1);
      chk(cpu_ext_irq_line0, 1'b1);
      wr(`TCX_IDX_SENSE, `TCX_SENSE_RISE);
      wr(`TCX_IDX_STATUS, 32'h0);
      ext_irq_line0_n <= 1'b1;
      tick(6);
      rc(`TCX_IDX_STATUS, 32'h1);
      $display("sense done");
   endtask
   // Slow memory answers the vector read with an address error
   task automatic t_error;
      mem.err_addr = VB + `TCX_VEC_OFS_LINE0;
      mem.wait_n = 2;
      wr(`TCX_IDX_ACT_A, 32'h8000);
      tick(40);
      rc(`TCX_IDX_CTRL, 32'h1);
      rc(`TCX_IDX_ACT_A, 32'h8000);
      chk(mem.get32(INFO + 8), 32'h80800000);
      $display("error done");
   endtask
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      ext_irq_line0_n = 1'b1;
      nmi_req = 1'b0;
      for (int i = 0; i < 128; i++) mem.m[SRC + i] = i[7:0];
      mem.m[DST + 128] = 8'h5a;
      mem.put32(VB + `TCX_VEC_OFS_LINE0, INFO);
      mem.put32(INFO, {8'h88, SRC[23:0]});
      mem.put32(INFO + 4, {8'h08, DST[23:0]});
      mem.put32(INFO + 8, 32'h80800001);
      tick(4);
      rstn <= 1'b1;
      tick(1);
      t_regs;
      t_gate;
      t_result;
      t_sense;
      t_error;
      wrap_up;
   end
endmodule // tcx_transfer_ctrl_tb
